// ---- rtl/sw_mon_pkg.sv ----
// Purpose: Shared constants for the switch monitor link and both ends
// Assumes: 250 MHz system clock on both ends
// Notes:   Operation list below
// Operation
// - Status bit from threshold compare, polarity programmable on programmable inputs only
// - Fixed 24-bit response: flags, programmable, ground inputs
// - Enabled switch change raises interrupt; timed wetting boost
// - Interrupt held low until host status read
// - Change during select keeps interrupt at deselect
// - Host may poll instead; short transitions lost
// - Only valid sleep command enters sleep
// - Settings kept unchanged during sleep
// - Listed wake events return sleep to normal
// - First response after select wake discarded
// - Sleep command: interrupt timer 5:3, scan 2:0
// - Interrupt timer doubles per code; 111 disables
// - Interrupt timer expiry raises interrupt, wakes
// - Scan timer: 000 none, doubles from 001
// - Scan window, then compare against pre-sleep states
// - Scan change wakes; otherwise restart and sleep
// - Both sleep timers idle in normal mode
// - Thermal: interrupt, flag, high current derated
// - Thermal flag clears at deselect once cooled
// - Open reads zero, closed reads one
// - Sleep opcode in upper eight bits, decoded first
package sw_mon_pkg;
    localparam int RESP_W = 24;
    localparam int N_PROG = 8;
    localparam int N_GND  = 14;
    localparam int N_IN   = 22;
    localparam int OP_HI  = 23;
    localparam int OP_LO  = 16;
    localparam int IT_HI  = 5;
    localparam int IT_LO  = 3;
    localparam int ST_HI  = 2;
    localparam int ST_LO  = 0;
    localparam logic [7:0] SLEEP_OP  = 8'h0c;
    localparam logic [2:0] IT_OFF    = 3'h7;
    localparam logic [2:0] ST_NONE   = 3'h0;
    localparam int CLK_MHZ      = 250;
    localparam int INT_BASE_MS  = 32;
    localparam int SCAN_BASE_US = 1000;
    localparam int SCAN_WIN_US  = 125;
    localparam int WET_MS       = 20;
    localparam int INT_BASE_CYC = INT_BASE_MS * 1000 * CLK_MHZ;
    localparam int SCAN_BASE_CYC = SCAN_BASE_US * CLK_MHZ;
    localparam int SCAN_WIN_CYC = SCAN_WIN_US * CLK_MHZ;
    localparam int WET_CYC      = WET_MS * 1000 * CLK_MHZ;
    localparam int SCLK_HALF    = 8;
    localparam logic [1:0] A_CMD  = 2'h0;
    localparam logic [1:0] A_STAT = 2'h1;
    localparam logic [1:0] A_RESP = 2'h2;
    localparam logic [1:0] A_WAKE = 2'h3;
    typedef enum logic [1:0] {
        M_NORMAL = 2'b00,
        M_SLEEP  = 2'b01,
        M_SCAN   = 2'b10
    } mode_t;
    typedef enum logic [2:0] {
        H_IDLE  = 3'b000,
        H_LEAD  = 3'b001,
        H_LOW   = 3'b010,
        H_HIGH  = 3'b011,
        H_TRAIL = 3'b100,
        H_GAP   = 3'b101
    } hstate_t;
endpackage

// ---- rtl/sw_mon_if.sv ----
// Purpose: Serial link, wake pin and open-drain interrupt line
// Assumes: Interrupt line pulled high, data out pulled low when idle
// Notes:   Enables are active low
`timescale 1ns/1ps
interface sw_mon_if;
    logic cs_n;
    logic sclk;
    logic si;
    logic wake_n;
    logic so_o;
    logic so_oe_n;
    logic int_o;
    logic int_oe_n;
    logic so_line;
    logic int_line;
    assign so_line  = so_oe_n ? 1'b0 : so_o;
    assign int_line = int_oe_n ? 1'b1 : int_o;
    modport device (
        input  cs_n, sclk, si, wake_n, int_line,
        output so_o, so_oe_n, int_o, int_oe_n
    );
    modport host (
        output cs_n, sclk, si, wake_n,
        input  so_line, int_line
    );
endinterface

// ---- rtl/sw_mon_host.sv ----
// Purpose: Serial master for the switch monitor with a command port
// Assumes: Software writes frames at A_CMD and reads results
// Notes:   Makes the serial clock by dividing clk
`timescale 1ns/1ps
module sw_mon_host #(
    parameter int HALF = sw_mon_pkg::SCLK_HALF
) (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic [1:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [31:0] rdata,
    output logic             int_pending,
    sw_mon_if.host           lnk
);
    import sw_mon_pkg::*;
    if (HALF < 6 || HALF > 255) begin : g_chk
        $error("HALF out of range");
    end
    hstate_t     st_r;
    logic [7:0]  cnt_r;
    logic [4:0]  bit_r;
    logic [23:0] tx_r, cmd_r, rx_r, resp_r;
    logic        again_r, slept_r, cs_r, sck_r, wake_r;
    logic [1:0]  s1_r, s2_r;
    logic [31:0] rdata_r;
    wire         so_s  = s2_r[1];
    wire         int_s = s2_r[0];
    wire         last  = (cnt_r == 8'h01);
    wire         busy  = (st_r != H_IDLE);
    wire         start = wr & (addr == A_CMD) & ~busy;
    wire         frame_end = (st_r == H_TRAIL) & last;
    // ----------------------------------------
    // Pin sampling and outputs
    // ----------------------------------------
    always_ff @(posedge clk) begin
        s1_r <= {lnk.so_line, lnk.int_line};
        s2_r <= s1_r;
    end
    assign lnk.cs_n   = cs_r;
    assign lnk.sclk   = sck_r;
    assign lnk.si     = tx_r[23];
    assign lnk.wake_n = wake_r;
    assign int_pending = ~int_s;
    assign rdata = rdata_r;
    // ----------------------------------------
    // Command port
    // ----------------------------------------
    wire [31:0] rd_mux = (addr == A_STAT) ? {30'h0, busy, ~int_s} :
                         (addr == A_RESP) ? {8'h0, resp_r} : 32'h0;
    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_r <= 32'h0;
            wake_r  <= 1'b1;
        end else begin
            rdata_r <= rd ? rd_mux : 32'h0;
            if (wr && addr == A_WAKE) begin
                wake_r <= wdata[0];
            end
        end
    end
    // ----------------------------------------
    // Frame engine
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            st_r    <= H_IDLE;
            cnt_r   <= 8'h0;
            bit_r   <= 5'h0;
            tx_r    <= 24'h0;
            cmd_r   <= 24'h0;
            rx_r    <= 24'h0;
            resp_r  <= 24'h0;
            again_r <= 1'b0;
            slept_r <= 1'b0;
            cs_r    <= 1'b1;
            sck_r   <= 1'b0;
        end else begin
            cnt_r <= last ? 8'(HALF) : cnt_r - 8'h01;
            case (st_r)
                H_IDLE: begin
                    cnt_r <= 8'(HALF);
                    if (start) begin
                        tx_r    <= wdata[23:0];
                        cmd_r   <= wdata[23:0];
                        again_r <= slept_r;
                        slept_r <= (wdata[OP_HI:OP_LO] == SLEEP_OP);
                        cs_r    <= 1'b0;
                        bit_r   <= 5'h0;
                        st_r    <= H_LEAD;
                    end
                end
                H_LEAD: if (last) st_r <= H_LOW;
                H_LOW: if (last) begin
                    rx_r  <= {rx_r[22:0], so_s};
                    sck_r <= 1'b1;
                    st_r  <= H_HIGH;
                end
                H_HIGH: if (last) begin
                    sck_r <= 1'b0;
                    tx_r  <= {tx_r[22:0], 1'b0};
                    bit_r <= bit_r + 5'h01;
                    st_r  <= (bit_r == 5'(RESP_W - 1)) ? H_TRAIL : H_LOW;
                end
                H_TRAIL: if (last) begin
                    cs_r <= 1'b1;
                    st_r <= H_GAP;
                    if (!again_r) begin
                        resp_r <= rx_r;
                    end
                end
                H_GAP: if (last) begin
                    if (again_r) begin
                        again_r <= 1'b0;
                        tx_r    <= cmd_r;
                        cs_r    <= 1'b0;
                        bit_r   <= 5'h0;
                        st_r    <= H_LEAD;
                    end else begin
                        st_r <= H_IDLE;
                    end
                end
                default: st_r <= H_IDLE;
            endcase
        end
    end
endmodule // sw_mon_host

// ---- rtl/sw_mon_device.sv ----
// Purpose: Switch status reporting, interrupt and sleep/wake control
// Assumes: Comparator outputs and link pins are asynchronous
// Notes:   Pin-below-threshold inputs come from the input comparators
`timescale 1ns/1ps
module sw_mon_device #(
    parameter int INT_BASE  = sw_mon_pkg::INT_BASE_CYC,
    parameter int SCAN_BASE = sw_mon_pkg::SCAN_BASE_CYC,
    parameter int SCAN_WIN  = sw_mon_pkg::SCAN_WIN_CYC,
    parameter int WET_TIME  = sw_mon_pkg::WET_CYC
) (
    input  wire logic                         clk,
    input  wire logic                         srst,
    sw_mon_if.device                          lnk,
    input  wire logic [sw_mon_pkg::N_PROG-1:0] prog_pin_low,
    input  wire logic [sw_mon_pkg::N_GND-1:0]  gnd_pin_low,
    input  wire logic [sw_mon_pkg::N_PROG-1:0] prog_to_supply,
    input  wire logic                         irq_en,
    input  wire logic                         die_hot,
    input  wire logic                         wet_high_cfg,
    input  wire logic                         wet_timer_en,
    output logic      [sw_mon_pkg::N_IN-1:0]   wet_high,
    output logic                              inputs_active,
    output logic                              asleep
);
    import sw_mon_pkg::*;
    localparam int SW = N_IN + 6;
    if (INT_BASE < 2 || INT_BASE > 8388608 || SCAN_BASE < 2 || SCAN_BASE > 33554432
        || SCAN_WIN < 2 || WET_TIME < 2) begin : g_chk
        $error("Timer parameter out of range");
    end
    // ----------------------------------------
    // Synchronisers and edge detect
    // ----------------------------------------
    logic [SW-1:0] s1_r, s2_r;
    logic [3:0]    d_r;
    always_ff @(posedge clk) begin
        s1_r <= {lnk.wake_n, lnk.cs_n, lnk.sclk, lnk.si, lnk.int_line, die_hot,
                 prog_pin_low, gnd_pin_low};
        s2_r <= s1_r;
        d_r  <= srst ? 4'hc : s2_r[SW-1:SW-4];
    end
    wire wake_s = s2_r[SW-1];
    wire cs_s   = s2_r[SW-2];
    wire sck_s  = s2_r[SW-3];
    wire si_s   = s2_r[SW-4];
    wire intl_s = s2_r[SW-5];
    wire hot_s  = s2_r[SW-6];
    wire wake_fall = d_r[3] & ~wake_s;
    wire cs_fall   = d_r[2] & ~cs_s;
    wire cs_rise   = ~d_r[2] & cs_s;
    wire sck_rise  = ~d_r[1] & sck_s;
    wire sck_fall  = d_r[1] & ~sck_s;
    logic intl_d_r;
    always_ff @(posedge clk) begin
        intl_d_r <= srst ? 1'b1 : intl_s;
    end
    wire intl_fall = intl_d_r & ~intl_s;
    // ----------------------------------------
    // Switch status
    // ----------------------------------------
    wire [N_PROG-1:0] prog_stat = s2_r[N_IN-1:N_GND] ^ prog_to_supply;
    wire [N_IN-1:0]   stat      = {prog_stat, s2_r[N_GND-1:0]};
    mode_t           mode_r;
    logic [N_IN-1:0] prev_r, snap_r, boost_r;
    logic            int_r, therm_r, cs_chg_r;
    wire normal = (mode_r == M_NORMAL);
    wire [N_IN-1:0] diff = stat ^ prev_r;
    wire change  = normal & (diff != '0);
    wire hot_on  = normal & hot_s;
    wire [RESP_W-1:0] resp = {therm_r, int_r, stat};
    // ----------------------------------------
    // Serial shifter
    // ----------------------------------------
    logic [RESP_W-1:0] tx_r, rx_r;
    logic [4:0]        bits_r;
    always_ff @(posedge clk) begin
        if (srst) begin
            tx_r   <= '0;
            rx_r   <= '0;
            bits_r <= 5'h0;
        end else if (cs_fall) begin
            tx_r   <= resp;
            bits_r <= 5'h0;
        end else if (!cs_s) begin
            if (sck_rise) begin
                rx_r   <= {rx_r[RESP_W-2:0], si_s};
                bits_r <= (bits_r == 5'(RESP_W)) ? bits_r : bits_r + 5'h01;
            end
            if (sck_fall) begin
                tx_r <= {tx_r[RESP_W-2:0], 1'b0};
            end
        end
    end
    assign lnk.so_o    = tx_r[RESP_W-1];
    assign lnk.so_oe_n = cs_s;
    wire sleep_cmd = normal & cs_rise & (bits_r == 5'(RESP_W))
                     & (rx_r[OP_HI:OP_LO] == SLEEP_OP);
    wire [2:0] it_code = rx_r[IT_HI:IT_LO];
    wire [2:0] st_code = rx_r[ST_HI:ST_LO];
    // ----------------------------------------
    // Sleep timers
    // ----------------------------------------
    logic [2:0]  it_r, st_r;
    logic [31:0] icnt_r, scnt_r, wcnt_r;
    wire [31:0] it_load = 32'(INT_BASE) << it_code;
    wire [31:0] st_load = 32'(SCAN_BASE) << (st_code - 3'h1);
    wire [31:0] st_reld = 32'(SCAN_BASE) << (st_r - 3'h1);
    wire it_exp   = !normal && (it_r != IT_OFF) && (icnt_r == 32'h1);
    wire scan_exp = (mode_r == M_SLEEP) && (st_r != ST_NONE) && (scnt_r == 32'h1);
    wire win_end  = (mode_r == M_SCAN) && (wcnt_r == 32'h1);
    wire scan_chg = win_end && (stat != snap_r);
    wire pin_wake = !normal && (wake_fall || cs_fall || (intl_fall && wake_s));
    // ----------------------------------------
    // Mode control
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            mode_r <= M_NORMAL;
            it_r   <= IT_OFF;
            st_r   <= ST_NONE;
            icnt_r <= 32'h0;
            scnt_r <= 32'h0;
            wcnt_r <= 32'h0;
            snap_r <= '0;
        end else begin
            case (mode_r)
                M_NORMAL: begin
                    icnt_r <= 32'h0;
                    scnt_r <= 32'h0;
                    if (sleep_cmd) begin
                        it_r   <= it_code;
                        st_r   <= st_code;
                        icnt_r <= it_load;
                        scnt_r <= st_load;
                        snap_r <= stat;
                        mode_r <= M_SLEEP;
                    end
                end
                M_SLEEP: begin
                    icnt_r <= icnt_r - 32'h1;
                    scnt_r <= scnt_r - 32'h1;
                    if (pin_wake || it_exp) begin
                        mode_r <= M_NORMAL;
                    end else if (scan_exp) begin
                        wcnt_r <= 32'(SCAN_WIN);
                        mode_r <= M_SCAN;
                    end
                end
                M_SCAN: begin
                    icnt_r <= icnt_r - 32'h1;
                    wcnt_r <= wcnt_r - 32'h1;
                    if (pin_wake || it_exp || scan_chg) begin
                        mode_r <= M_NORMAL;
                    end else if (win_end) begin
                        scnt_r <= st_reld;
                        mode_r <= M_SLEEP;
                    end
                end
                default: mode_r <= M_NORMAL;
            endcase
        end
    end
    // Configuration inputs are never altered by the mode logic
    assign asleep        = !normal;
    assign inputs_active = (mode_r != M_SLEEP);
    // ----------------------------------------
    // Interrupt and thermal flags
    // ----------------------------------------
    wire int_set = (irq_en & change)
                 | it_exp
                 | (irq_en & scan_chg)
                 | (hot_on & ~therm_r);
    wire int_clr = cs_rise & ~cs_chg_r;
    always_ff @(posedge clk) begin
        if (srst) begin
            int_r    <= 1'b0;
            therm_r  <= 1'b0;
            cs_chg_r <= 1'b0;
            prev_r   <= '0;
        end else begin
            int_r    <= int_set | (int_r & ~int_clr);
            therm_r  <= hot_on | (therm_r & ~(cs_rise & ~hot_s));
            cs_chg_r <= (change & irq_en & ~cs_s) | (cs_chg_r & ~cs_fall);
            if (normal) begin
                prev_r <= stat;
            end
        end
    end
    assign lnk.int_o    = 1'b0;
    assign lnk.int_oe_n = ~int_r;
    // ----------------------------------------
    // Wetting current boost
    // ----------------------------------------
    logic [31:0] wet_r;
    always_ff @(posedge clk) begin
        if (srst) begin
            boost_r <= '0;
            wet_r   <= 32'h0;
        end else if (change) begin
            boost_r <= boost_r | diff;
            wet_r   <= 32'(WET_TIME);
        end else if (wet_r != 32'h0) begin
            wet_r <= wet_r - 32'h1;
            if (wet_r == 32'h1) begin
                boost_r <= '0;
            end
        end
    end
    wire [N_IN-1:0] wet_sel = wet_timer_en ? boost_r : {N_IN{1'b1}};
    assign wet_high = (wet_high_cfg && normal && !hot_s) ? wet_sel : '0;
endmodule // sw_mon_device

// ---- testbench/sw_mon_props.sv ----
// Purpose: Link checks between the host and device ends
// Assumes: One clock domain, synchronous active-high reset
// Notes:   Watches the interface signals only
`timescale 1ns/1ps
module sw_mon_props (
    input wire logic clk,
    input wire logic srst,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic si,
    input wire logic wake_n,
    input wire logic so_o,
    input wire logic so_oe_n,
    input wire logic int_o,
    input wire logic int_oe_n,
    input wire logic so_line,
    input wire logic int_line
);
    logic [7:0] cs_hi_r;
    logic [7:0] cs_hi_nxt;
    logic [5:0] rises_r;
    logic [5:0] rises_nxt;
    logic       sclk_d_r;
    wire        sclk_rise = sclk & ~sclk_d_r;
    assign cs_hi_nxt = !cs_n ? 8'h00 : (cs_hi_r == 8'hff) ? cs_hi_r : cs_hi_r + 8'h01;
    assign rises_nxt = cs_n ? 6'h00 : rises_r + {5'h00, sclk_rise};
    always_ff @(posedge clk) begin
        if (srst) begin
            cs_hi_r  <= 8'h00;
            rises_r  <= 6'h00;
            sclk_d_r <= 1'b0;
        end else begin
            cs_hi_r  <= cs_hi_nxt;
            rises_r  <= rises_nxt;
            sclk_d_r <= sclk;
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    sequence s_idle8;
        cs_n [*8];
    endsequence
    sequence s_sclk_high;
        sclk ##1 sclk;
    endsequence
    chk_int_reset: assert property ($fell(srst) |-> int_oe_n)
        else $error("interrupt active after reset");
    chk_int_held: assert property ((s_idle8 ##0 !int_oe_n) |=> !int_oe_n)
        else $error("interrupt released without deselect");
    chk_int_release: assert property ($rose(int_oe_n) |-> cs_hi_r inside {[1:8]})
        else $error("interrupt released away from deselect");
    chk_int_drive: assert property (!int_oe_n |-> !int_o && !int_line)
        else $error("interrupt line not low when driven");
    chk_frame_bits: assert property ($rose(cs_n) |-> rises_r == 6'd24)
        else $error("frame not 24 clocks");
    chk_cs_gap: assert property ($rose(cs_n) |=> cs_n [*7])
        else $error("frames too close");
    chk_lead_low: assert property ($fell(cs_n) |-> !sclk [*8])
        else $error("serial clock too early");
    chk_sclk_idle: assert property (cs_n |-> !sclk)
        else $error("serial clock outside frame");
    chk_si_hold: assert property (s_sclk_high |-> $stable(si))
        else $error("data in moved while clock high");
    chk_so_hold: assert property (s_sclk_high |-> $stable(so_line))
        else $error("data out moved while clock high");
    chk_so_drive: assert property ($fell(cs_n) |-> ##[1:5] !so_oe_n)
        else $error("data out not driven after select");
    chk_so_release: assert property ($rose(cs_n) |-> ##[1:5] so_oe_n)
        else $error("data out not released");
endmodule // sw_mon_props

// ---- testbench/switch_monitor_sleep_wake_tb.sv ----
// Purpose: Self-checking bench for both ends of the switch monitor link
// Assumes: Device timers shortened by parameters
// Notes:   Random pin patterns come from a bench shift register
`timescale 1ns/1ps
module switch_monitor_sleep_wake_tb;
    import sw_mon_pkg::*;
    localparam int IB = 20;
    logic              clk            = 1'b0;
    logic              srst           = 1'b1;
    logic [1:0]        addr           = 2'h0;
    logic [31:0]       wdata          = 32'h0;
    logic              wr             = 1'b0;
    logic              rd             = 1'b0;
    logic [31:0]       rdata;
    logic              int_pending;
    logic [N_PROG-1:0] prog_pin_low   = 8'h00;
    logic [N_PROG-1:0] prog_to_supply = 8'h00;
    logic [N_GND-1:0]  gnd_pin_low    = 14'h0;
    logic              irq_en         = 1'b0;
    logic              die_hot        = 1'b0;
    logic              wet_high_cfg   = 1'b0;
    logic              wet_timer_en   = 1'b0;
    logic [N_IN-1:0]   wet_high;
    logic              inputs_active;
    logic              asleep;
    logic [31:0]       rnd            = 32'h20c321c1;
    logic [31:0]       d;
    logic [31:0]       v;
    logic [23:0]       r;
    logic [7:0]        ops [5]        = '{8'h00, 8'h0d, 8'h8c, 8'h4c, 8'h1c};
    int                n;
    int                miscompares    = 0;
    int                checks_done    = 0;
    int                falls          = 0;

    sw_mon_if lnk ();
    sw_mon_host i_sw_mon_host (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .int_pending(int_pending), .lnk(lnk));
    sw_mon_device #(.INT_BASE(IB), .SCAN_BASE(20), .SCAN_WIN(5), .WET_TIME(10)) i_sw_mon_device (
        .clk(clk), .srst(srst), .lnk(lnk), .prog_pin_low(prog_pin_low),
        .gnd_pin_low(gnd_pin_low), .prog_to_supply(prog_to_supply), .irq_en(irq_en),
        .die_hot(die_hot), .wet_high_cfg(wet_high_cfg), .wet_timer_en(wet_timer_en),
        .wet_high(wet_high), .inputs_active(inputs_active), .asleep(asleep));
    sw_mon_props i_sw_mon_props (.clk(clk), .srst(srst), .cs_n(lnk.cs_n), .sclk(lnk.sclk),
        .si(lnk.si), .wake_n(lnk.wake_n), .so_o(lnk.so_o), .so_oe_n(lnk.so_oe_n),
        .int_o(lnk.int_o), .int_oe_n(lnk.int_oe_n), .so_line(lnk.so_line),
        .int_line(lnk.int_line));

    always #2 clk = ~clk;
    always @(negedge lnk.cs_n) falls++;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [23:0] exp_resp(input logic th, input logic it);
        return {th, it, prog_pin_low ^ prog_to_supply, gnd_pin_low};
    endfunction
    function automatic logic [23:0] slp(input logic [2:0] it, input logic [2:0] st);
        return {SLEEP_OP, 10'h000, it, st};
    endfunction
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic bus_wr(input logic [1:0] a, input logic [31:0] dat);
        @(posedge clk);
        addr  <= a;
        wdata <= dat;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask
    task automatic bus_rd(input logic [1:0] a, output logic [31:0] dat);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        @(negedge clk);
        dat = rdata;
    endtask
    task automatic frame(input logic [23:0] cmd, input int flip, output logic [23:0] resp);
        int k;
        logic [31:0] s;
        bus_wr(A_CMD, {8'h00, cmd});
        if (flip >= 0) begin
            repeat (100) @(posedge clk);
            gnd_pin_low[flip] <= ~gnd_pin_low[flip];
        end
        k = 0;
        s = 32'h2;
        while (s[1] !== 1'b0 && k < 2000) begin
            bus_rd(A_STAT, s);
            k++;
        end
        check("frame_done", 32'h0, 32'(s[1]));
        bus_rd(A_RESP, s);
        resp = s[23:0];
    endtask
    task automatic wait_neg(input int c);
        repeat (c) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic wait_sleep(input logic lv, input int lim, output int c);
        c = 0;
        @(negedge clk);
        while (asleep !== lv && c < lim) begin
            @(negedge clk);
            c++;
        end
        check("asleep", 32'(lv), 32'(asleep));
    endtask
    task automatic count_active(input int cyc, output int c);
        c = 0;
        repeat (cyc) begin
            @(negedge clk);
            if (inputs_active === 1'b1) c++;
        end
    endtask
    task automatic finish_test();
        if (miscompares == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        #200000;
        miscompares++;
        finish_test();
    end

    initial begin
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            rnd = lfsr(rnd);
            v = (i == 0) ? 32'h0 : (i == 1) ? 32'hffffffff : rnd;
            @(posedge clk);
            prog_pin_low <= v[7:0];
            gnd_pin_low <= v[21:8];
            prog_to_supply <= v[29:22];
            repeat (8) @(posedge clk);
            gnd_pin_low[5] <= ~v[13];
            @(posedge clk);
            gnd_pin_low[5] <= v[13];
            frame(24'h0, -1, r);
            check("resp_poll", 32'(exp_resp(1'b0, 1'b0)), 32'(r));
        end
        @(posedge clk);
        irq_en <= 1'b1;
        repeat (8) @(posedge clk);
        gnd_pin_low[3] <= ~gnd_pin_low[3];
        repeat (300) @(posedge clk);
        bus_rd(A_STAT, d);
        check("int_held", 32'h1, 32'(d[0]));
        check("int_pin", 32'h1, 32'(int_pending));
        frame(24'h0, -1, r);
        check("resp_int", 32'(exp_resp(1'b0, 1'b1)), 32'(r));
        bus_rd(A_STAT, d);
        check("int_ack", 32'h0, 32'(d[0]));
        frame(24'h0, 4, r);
        bus_rd(A_STAT, d);
        check("int_kept", 32'h1, 32'(d[0]));
        frame(24'h0, -1, r);
        check("resp_kept", 32'(exp_resp(1'b0, 1'b1)), 32'(r));
        @(posedge clk);
        wet_high_cfg <= 1'b1;
        wet_timer_en <= 1'b1;
        gnd_pin_low[0] <= 1'b0;
        repeat (40) @(posedge clk);
        gnd_pin_low[0] <= 1'b1;
        wait_neg(7);
        check("wet_boost", 32'h1, 32'(wet_high));
        wait_neg(40);
        check("wet_timeout", 32'h0, 32'(wet_high));
        @(posedge clk);
        wet_timer_en <= 1'b0;
        wait_neg(4);
        check("wet_steady", 32'({N_IN{1'b1}}), 32'(wet_high));
        frame(24'h0, -1, r);
        @(posedge clk);
        die_hot <= 1'b1;
        bus_rd(A_STAT, d);
        repeat (10) @(posedge clk);
        bus_rd(A_STAT, d);
        check("hot_int", 32'h1, 32'(d[0]));
        @(posedge clk);
        gnd_pin_low[0] <= 1'b0;
        wait_neg(7);
        check("wet_derate", 32'h0, 32'(wet_high));
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            if (k == 2) die_hot <= 1'b0;
            frame(24'h0, -1, r);
            check("therm_flag", 32'(k < 3), 32'(r[23]));
        end
        check("wet_restore", 32'({N_IN{1'b1}}), 32'(wet_high));
        foreach (ops[j]) begin
            frame({ops[j], 16'h0038}, -1, r);
            wait_neg(20);
            check("stay_normal", 32'h0, 32'(asleep));
        end
        for (int it = 2; it < 4; it++) begin
            frame(slp(3'(it), ST_NONE), -1, r);
            check("sleep_entry", 32'h1, 32'(asleep));
            wait_sleep(1'b0, 400, n);
            check("int_period", 32'h1, 32'(n > (IB << it) - 50 && n < (IB << it) + 20));
            repeat (4) @(posedge clk);
            bus_rd(A_STAT, d);
            check("timer_int", 32'h1, 32'(d[0]));
            frame(24'h0, -1, r);
            repeat (500) @(posedge clk);
            bus_rd(A_STAT, d);
            check("timers_idle", 32'h0, 32'(d[0]));
        end
        frame(slp(IT_OFF, ST_NONE), -1, r);
        count_active(1000, n);
        check("no_scan", 32'h0, 32'(n));
        check("no_timer_wake", 32'h1, 32'(asleep));
        bus_wr(A_WAKE, 32'h0);
        wait_sleep(1'b0, 12, n);
        bus_wr(A_WAKE, 32'h1);
        frame(slp(IT_OFF, 3'h2), -1, r);
        count_active(400, n);
        check("scan_windows", 32'h1, 32'(n >= 30 && n <= 60));
        check("scan_quiet", 32'h1, 32'(asleep));
        @(posedge clk);
        gnd_pin_low[6] <= ~gnd_pin_low[6];
        wait_sleep(1'b0, 80, n);
        repeat (4) @(posedge clk);
        bus_rd(A_STAT, d);
        check("scan_int", 32'h1, 32'(d[0]));
        frame(24'h0, -1, r);
        frame(slp(IT_OFF, ST_NONE), -1, r);
        n = falls;
        frame(24'h0, -1, r);
        check("cs_wake_retry", 32'(n + 2), 32'(falls));
        check("resp_cs_wake", 32'(exp_resp(1'b0, 1'b0) & 24'hbfffff), 32'(r & 24'hbfffff));
        check("woke_cs", 32'h0, 32'(asleep));
        finish_test();
    end
endmodule // switch_monitor_sleep_wake_tb
